// [design/gpio_port_defs.vh]
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

// Printed offsets are not word multiples: byte address is index times four
`define IDX_PORT_B_LATCH      8'h01
`define IDX_PORT_C_LATCH      8'h02
`define IDX_PORT_D_LATCH      8'h03
`define IDX_PORT_B_DIRECTION  8'h05
`define IDX_PORT_C_DIRECTION  8'h06
`define IDX_PORT_D_DIRECTION  8'h07
`define IDX_PORT_E_LATCH      8'h08
`define IDX_PORT_E_DIRECTION  8'h0c
`define IDX_PIN_CONFIG        8'h10

`define DIR_RESET             8'h00
`define C_IMPL_MASK           8'h3f
`define C_DIR_MASK            8'hbf
`define CLKOUT_BIT            7
`define CLKOUT_PIN            2
`define TIMER_A_PIN           6
`define TIMER_B_PIN           4
`define ANALOG_D_FIRST        5'h08
`define ANALOG_D_LAST         5'h0e
`define ANALOG_B_LAST         5'h07
`define PS_EXT_CLOCK          3'h7
`define ZERO8                 8'h00
`define ZERO32                32'h0000_0000

`endif

// [design/parallel_io_ports_b_to_e.v]
// Function
// - Port B read gives latch where direction is one, else pin level.
// - Data writes always load the latch; input-mode pin reads unaffected.
// - Port C has six latch bits; reset leaves latches unchanged.
// - Clock-output enable drives system clock on port C pin 2.
// - Clock-output enable is read/write and cleared by reset.
// - Port C direction one drives pin; reset makes all inputs.
// - Port C read gives latch where direction is one, else pin; bit 2 reads zero while clock output is enabled.
// - Port D has eight latch bits steered by direction bits.
// - Port D analog channel bit reads zero if input, else latch.
// - Timer-used port D pins: direction selects latch or zero only.
// - External timer clock: pin 6 to timer A, pin 4 to timer B.
// - Port D direction one drives pin except analog and timer pins; reset makes all inputs.
// - Port D read gives latch where direction is one, else pin, except analog and timer pins, which read latch or zero.
// - Port E has eight latch bits steered by direction bits.
// - Port B input pin is high impedance; output drives latch.
// - Port C data bits 7 and 6 read zero.
`timescale 1ns/1ps
`include "gpio_port_defs.vh"

module parallel_io_ports_b_to_e #(
  parameter W = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  input  wire          sys_clock,
  input  wire [4:0]    adc_channel_select,
  input  wire [2:0]    timer_a_prescaler_select,
  input  wire [2:0]    timer_b_prescaler_select,
  input  wire [W-1:0]  port_b_in,
  input  wire [W-1:0]  port_c_in,
  input  wire [W-1:0]  port_d_in,
  input  wire [W-1:0]  port_e_in,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  output reg  [W-1:0]  port_b_out,
  output reg  [W-1:0]  port_b_oe_n,
  output reg  [W-1:0]  port_c_out,
  output reg  [W-1:0]  port_c_oe_n,
  output reg  [W-1:0]  port_d_out,
  output reg  [W-1:0]  port_d_oe_n,
  output reg  [W-1:0]  port_e_out,
  output reg  [W-1:0]  port_e_oe_n,
  output reg           timer_a_ext_clock,
  output reg           timer_b_ext_clock
);

  ////////////////////////////////////////////////////////////////////////////
  reg  [W-1:0] port_b_latch_reg;
  reg  [W-1:0] port_c_latch_reg;
  reg  [W-1:0] port_d_latch_reg;
  reg  [W-1:0] port_e_latch_reg;
  reg  [W-1:0] port_b_direction_reg;
  reg  [W-1:0] port_c_direction_reg;
  reg  [W-1:0] port_d_direction_reg;
  reg  [W-1:0] port_e_direction_reg;
  reg  [31:0]  prdata_next;
  reg          hit_next;
  wire [9:0]   word_idx;
  wire         setup;
  wire         wr;
  wire         clock_out_enable;
  wire [W-1:0] analog_d;
  wire [W-1:0] timer_d;
  wire         ext_a;
  wire         ext_b;
  wire [W-1:0] c_pin_own;
  wire [W-1:0] d_dir_eff;
  wire [W-1:0] b_read;
  wire [W-1:0] c_read;
  wire [W-1:0] d_read;
  wire [W-1:0] e_read;
  wire         wr_b_latch;
  wire         wr_c_latch;
  wire         wr_d_latch;
  wire         wr_e_latch;
  wire         wr_b_dir;
  wire         wr_c_dir;
  wire         wr_d_dir;
  wire         wr_e_dir;

  // Latch where direction is one, pin where it is zero
  function [W-1:0] pick;
    input [W-1:0] dir;
    input [W-1:0] latch;
    input [W-1:0] pin;
    begin
      pick = (dir & latch) | (~dir & pin);
    end
  endfunction

  // Access phase of a write to the register at the given index
  function write_hit;
    input       strobe;
    input [9:0] idx;
    input [7:0] target;
    begin
      write_hit = strobe && (idx == {2'b00, target});
    end
  endfunction

  assign word_idx = paddr[11:2];
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pready & pwrite;
  assign clock_out_enable = port_c_direction_reg[`CLKOUT_BIT];
  assign ext_a = timer_a_prescaler_select == `PS_EXT_CLOCK;
  assign ext_b = timer_b_prescaler_select == `PS_EXT_CLOCK;

  // Port D analog channel map: channel 8 upward is pin 0 upward
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_map
      assign analog_d[g] = (adc_channel_select >= `ANALOG_D_FIRST) &&
                           (adc_channel_select <= `ANALOG_D_LAST) &&
                           (adc_channel_select[2:0] == g);
    end
  endgenerate

  assign timer_d = ({{(W-1){1'b0}}, ext_a} << `TIMER_A_PIN) |
                   ({{(W-1){1'b0}}, ext_b} << `TIMER_B_PIN);
  assign c_pin_own = {{(W-1){1'b0}}, clock_out_enable} << `CLKOUT_PIN;
  assign d_dir_eff = port_d_direction_reg & ~timer_d & ~analog_d;

  // Write strobes, one per register
  assign wr_b_latch = write_hit(wr, word_idx, `IDX_PORT_B_LATCH);
  assign wr_c_latch = write_hit(wr, word_idx, `IDX_PORT_C_LATCH);
  assign wr_d_latch = write_hit(wr, word_idx, `IDX_PORT_D_LATCH);
  assign wr_e_latch = write_hit(wr, word_idx, `IDX_PORT_E_LATCH);
  assign wr_b_dir   = write_hit(wr, word_idx, `IDX_PORT_B_DIRECTION);
  assign wr_c_dir   = write_hit(wr, word_idx, `IDX_PORT_C_DIRECTION);
  assign wr_d_dir   = write_hit(wr, word_idx, `IDX_PORT_D_DIRECTION);
  assign wr_e_dir   = write_hit(wr, word_idx, `IDX_PORT_E_DIRECTION);

  // Read values of the data registers
  assign b_read = pick(port_b_direction_reg, port_b_latch_reg,
                       port_b_in);
  assign c_read = pick(port_c_direction_reg, port_c_latch_reg, port_c_in)
                  & `C_IMPL_MASK & ~c_pin_own;
  assign d_read = (pick(port_d_direction_reg, port_d_latch_reg, port_d_in)
                   & ~(analog_d | timer_d))
                  | (port_d_direction_reg & port_d_latch_reg
                     & (analog_d | timer_d));
  assign e_read = pick(port_e_direction_reg, port_e_latch_reg,
                       port_e_in);

  ////////////////////////////////////////////////////////////////////////////
  // Register read multiplexer
  always @*
  begin
    prdata_next = `ZERO32;
    hit_next    = 1'b1;
    case (word_idx[7:0])
      `IDX_PORT_B_LATCH:
      begin
        prdata_next[W-1:0] = b_read;
      end
      `IDX_PORT_C_LATCH:
      begin
        prdata_next[W-1:0] = c_read;
      end
      `IDX_PORT_D_LATCH:
      begin
        prdata_next[W-1:0] = d_read;
      end
      `IDX_PORT_E_LATCH:
      begin
        prdata_next[W-1:0] = e_read;
      end
      `IDX_PORT_B_DIRECTION:
      begin
        prdata_next[W-1:0] = port_b_direction_reg;
      end
      `IDX_PORT_C_DIRECTION:
      begin
        prdata_next[W-1:0] = port_c_direction_reg;
      end
      `IDX_PORT_D_DIRECTION:
      begin
        prdata_next[W-1:0] = port_d_direction_reg;
      end
      `IDX_PORT_E_DIRECTION:
      begin
        prdata_next[W-1:0] = port_e_direction_reg;
      end
      default:
      begin
        hit_next = 1'b0;
      end
    endcase
    if (word_idx[9:8] != 2'b00)
    begin
      hit_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // No wait state: answer in the cycle after setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ZERO32;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit_next;
      prdata  <= (setup & ~pwrite & hit_next) ? prdata_next : `ZERO32;
    end
  end

  // Latches have no reset value; they load only on writes
  always @(posedge pclk)
  begin
    if (wr_b_latch)
    begin
      port_b_latch_reg <= pwdata[W-1:0];
    end
    if (wr_c_latch)
    begin
      port_c_latch_reg <= pwdata[W-1:0] & `C_IMPL_MASK;
    end
    if (wr_d_latch)
    begin
      port_d_latch_reg <= pwdata[W-1:0];
    end
    if (wr_e_latch)
    begin
      port_e_latch_reg <= pwdata[W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_b_direction_reg <= `DIR_RESET;
      port_c_direction_reg <= `DIR_RESET;
      port_d_direction_reg <= `DIR_RESET;
      port_e_direction_reg <= `DIR_RESET;
    end
    else
    begin
      if (wr_b_dir)
      begin
        port_b_direction_reg <= pwdata[W-1:0];
      end
      if (wr_c_dir)
      begin
        port_c_direction_reg <= pwdata[W-1:0] & `C_DIR_MASK;
      end
      if (wr_d_dir)
      begin
        port_d_direction_reg <= pwdata[W-1:0];
      end
      if (wr_e_dir)
      begin
        port_e_direction_reg <= pwdata[W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered; enables are active low
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_b_out  <= `ZERO8;
      port_b_oe_n <= ~`ZERO8;
    end
    else
    begin
      port_b_out  <= port_b_latch_reg;
      port_b_oe_n <= ~port_b_direction_reg;
    end
  end

  // Clock output takes pin 2 over whatever its direction bit says
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_c_out  <= `ZERO8;
      port_c_oe_n <= ~`ZERO8;
    end
    else
    begin
      port_c_out  <= (port_c_latch_reg & ~c_pin_own)
                     | (c_pin_own & {W{sys_clock}});
      port_c_oe_n <= ~((port_c_direction_reg & `C_IMPL_MASK)
                       | c_pin_own);
    end
  end

  // Analog and timer pins stay released whatever their direction bit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_d_out  <= `ZERO8;
      port_d_oe_n <= ~`ZERO8;
    end
    else
    begin
      port_d_out  <= port_d_latch_reg;
      port_d_oe_n <= ~d_dir_eff;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_e_out  <= `ZERO8;
      port_e_oe_n <= ~`ZERO8;
    end
    else
    begin
      port_e_out  <= port_e_latch_reg;
      port_e_oe_n <= ~port_e_direction_reg;
    end
  end

  // External timer clocks taken from their port D pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_a_ext_clock <= 1'b0;
      timer_b_ext_clock <= 1'b0;
    end
    else
    begin
      timer_a_ext_clock <= ext_a & port_d_in[`TIMER_A_PIN];
      timer_b_ext_clock <= ext_b & port_d_in[`TIMER_B_PIN];
    end
  end

endmodule // parallel_io_ports_b_to_e

// [verif/parallel_io_ports_b_to_e_tb.sv]
`timescale 1ns/1ps
module parallel_io_ports_b_to_e_tb;
  reg         pclk, presetn, psel, penable, pwrite, sys_clock, e;
  reg  [11:0] paddr, la;
  reg  [31:0] pwdata, ext;
  reg  [4:0]  adc;
  reg  [2:0]  tas, tbs;
  reg  [7:0]  r;
  wire [31:0] prdata, pins, outs, oe;
  wire        pready, pslverr, ta, tb;
  integer     err_total, samples_checked, cyc, i, p;
  parallel_io_ports_b_to_e parallel_io_ports_b_to_e_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .sys_clock(sys_clock),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_channel_select(adc), .timer_a_prescaler_select(tas),
    .timer_b_prescaler_select(tbs), .port_b_in(pins[7:0]),
    .port_c_in(pins[15:8]), .port_d_in(pins[23:16]),
    .port_e_in(pins[31:24]), .port_b_out(outs[7:0]),
    .port_c_out(outs[15:8]), .port_d_out(outs[23:16]),
    .port_e_out(outs[31:24]), .port_b_oe_n(oe[7:0]),
    .port_c_oe_n(oe[15:8]), .port_d_oe_n(oe[23:16]),
    .port_e_oe_n(oe[31:24]), .timer_a_ext_clock(ta),
    .timer_b_ext_clock(tb));
  pin_env pin_env_inst (.drv_out(outs), .drv_oe_n(oe), .ext(ext), .pins(pins));
  always #12.5 pclk = ~pclk;
  ////////////////////////////////////////
  task chk(input string n, input [7:0] x, input [7:0] g);
    samples_checked = samples_checked + 1;
    if (g !== x)
    begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [11:0] a, input [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [11:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  task t_reset;
    for (i = 0; i < 4; i++)
    begin
      la = (i == 3) ? 12'h030 : 12'(12'h014 + i * 4);
      rd(la);
      chk("dir", 8'h00, r);
      chk("oe", 8'hff, oe[i*8 +: 8]);
    end
  endtask
  task t_ports;
    ext <= 32'h3c3c_3c3c;
    for (i = 0; i < 3; i++)
    begin
      la = (i == 0) ? 12'h004 : (i == 1) ? 12'h00c : 12'h020;
      p = (i == 0) ? 0 : (i == 1) ? 16 : 24;
      wr(la, 8'ha5);
      wr(la + 12'h010, 8'h0f);
      rd(la);
      chk("mix", 8'h35, r);
      chk("oe", 8'hf0, oe[p +: 8]);
      chk("pin", 8'h35, pins[p +: 8]);
      wr(la, 8'h5a);
      rd(la);
      chk("inwr", 8'h3a, r);
    end
  endtask
  task t_port_c;
    wr(12'h008, 8'hc5);
    wr(12'h018, 8'h0f);
    ext <= 32'hffff_ffff;
    rd(12'h008);
    chk("c", 8'h35, r);
    wr(12'h018, 8'hff);
    rd(12'h018);
    chk("cdir", 8'hbf, r);
    wr(12'h018, 8'h80);
    sys_clock <= 1'b1;
    rd(12'h008);
    chk("cclk", 8'h3b, r);
    chk("coe", 8'hfb, oe[15:8]);
    wr(12'h008, 8'h2a);
    chk("clk1", 8'h01, {7'h00, outs[10]});
    sys_clock <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("clk0", 8'h00, {7'h00, outs[10]});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h018);
    chk("cdir", 8'h00, r);
    wr(12'h018, 8'h3f);
    rd(12'h008);
    chk("ckeep", 8'h2a, r);
  endtask
  task t_analog;
    wr(12'h01c, 8'h00);
    wr(12'h00c, 8'h00);
    for (i = 8; i < 15; i++)
    begin
      adc <= i[4:0];
      rd(12'h00c);
      chk("adc", 8'hff ^ (8'h01 << (i - 8)), r);
    end
    adc <= 5'h0b;
    wr(12'h00c, 8'h08);
    wr(12'h01c, 8'h08);
    ext <= 32'hfff7_ffff;
    rd(12'h00c);
    chk("adcl", 8'hff, r);
    adc <= 5'h1f;
    ext <= 32'hffff_ffff;
  endtask
  task t_timer;
    tas <= 3'h7;
    tbs <= 3'h7;
    wr(12'h00c, 8'h50);
    wr(12'h01c, 8'hff);
    rd(12'h00c);
    chk("dtim", 8'h50, r);
    chk("doe", 8'h50, oe[23:16]);
    chk("tclk", 8'h03, {6'h00, ta, tb});
    wr(12'h01c, 8'h00);
    rd(12'h00c);
    chk("dtz", 8'haf, r);
    ext <= 32'hffaf_ffff;
    repeat (3) @(posedge pclk);
    chk("tclk", 8'h00, {6'h00, ta, tb});
    wr(12'h02c, 8'hff);
    chk("err", 8'h01, {7'h00, e});
    rd(12'h02c);
    chk("errd", 8'h01, {7'h00, e});
  endtask
  task summarize;
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      summarize;
    end
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, sys_clock} = 6'h00;
    {paddr, pwdata, ext, tas, tbs} = '0;
    adc = 5'h1f;
    {err_total, samples_checked, cyc} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ports;
    t_port_c;
    t_analog;
    t_timer;
    summarize;
  end
endmodule // parallel_io_ports_b_to_e_tb

// [verif/pin_env.sv]
`timescale 1ns/1ps
module pin_env (
  input  wire [31:0] drv_out,
  input  wire [31:0] drv_oe_n,
  input  wire [31:0] ext,
  output wire [31:0] pins
);
  // Driven pins show the block's value, released pins the outside level
  assign pins = (drv_oe_n & ext) | (~drv_oe_n & drv_out);
endmodule // pin_env

// [verif/pio_checker_asserts.sv]
`timescale 1ns/1ps
module pio_checker #(parameter W = 8) (
  input wire         pclk,
  input wire         presetn,
  input wire         psel,
  input wire         penable,
  input wire         pwrite,
  input wire [11:0]  paddr,
  input wire [31:0]  prdata,
  input wire         pready,
  input wire         pslverr,
  input wire [W-1:0] port_c_oe_n,
  input wire [W-1:0] port_d_oe_n,
  input wire [W-1:0] port_d_in,
  input wire [2:0]   timer_a_prescaler_select,
  input wire [2:0]   timer_b_prescaler_select,
  input wire         timer_a_ext_clock,
  input wire         timer_b_ext_clock
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("stray read data");
  a_c_top_zero: assert property (
    pready && !pwrite && paddr == 12'h008 |-> prdata[7:6] == 2'b00)
    else $error("port c top bits set");
  a_c_top_hiz: assert property (port_c_oe_n[7:6] == 2'b11)
    else $error("port c top pins driven");
  a_d_dir_write: assert property (
    $changed(port_d_oe_n[7]) |-> $past(psel && penable && pwrite, 2))
    else $error("port d direction moved");
  a_tim_a_clk: assert property (
    presetn |=> timer_a_ext_clock ==
    ($past(timer_a_prescaler_select) == 3'h7 && $past(port_d_in[6])))
    else $error("timer a clock wrong");
  a_tim_b_clk: assert property (
    presetn |=> timer_b_ext_clock ==
    ($past(timer_b_prescaler_select) == 3'h7 && $past(port_d_in[4])))
    else $error("timer b clock wrong");
  c_err: cover property (pslverr);
  c_tim: cover property (timer_a_ext_clock && timer_b_ext_clock);
  c_clk_en: cover property ($fell(port_c_oe_n[2]));
endmodule // pio_checker
bind parallel_io_ports_b_to_e pio_checker #(.W(W)) chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_c_oe_n(port_c_oe_n), .port_d_oe_n(port_d_oe_n),
  .port_d_in(port_d_in),
  .timer_a_prescaler_select(timer_a_prescaler_select),
  .timer_b_prescaler_select(timer_b_prescaler_select),
  .timer_a_ext_clock(timer_a_ext_clock),
  .timer_b_ext_clock(timer_b_ext_clock));
